/* verilog/pscr_regs.sv */
// Pin status and configuration register bank
`timescale 1ns/100ps
module pscr_regs (
  input  wire logic               clock,
  input  wire logic               reset,
  input  wire logic               bus_access,
  input  wire logic               bus_write,
  input  wire logic [7:0]         bus_addr,
  input  wire logic [7:0]         bus_wdata,
  output logic      [7:0]         bus_rdata,
  output logic                    bus_hit,
  input  wire logic               port_enable_pin,
  input  wire logic               mode_sel2_pin,
  input  wire logic               mode_sel1_pin,
  input  wire logic               emulation_enable_pin,
  input  wire logic               polarity_pin,
  input  wire logic               port_enable_override,
  input  wire logic               mode_sel2_override,
  input  wire logic               mode_sel1_override,
  input  wire logic               emulation_enable_override,
  input  wire logic               override_select,
  input  wire pscr_pkg::pscr_power_t core_power_state,
  output logic                    wake_request,
  output logic [7:0]              general_config,
  output logic [7:0]              emulation_config,
  output logic [7:0]              switch_config,
  output logic [7:0]              attach_detect_config,
  output logic [7:0]              fast_data_switch_config,
  output logic                    bus_discharge,
  output logic                    rationing_enable,
  output logic                    rationing_reset,
  output pscr_pkg::pscr_ration_t  rationing_behaviour,
  output logic                    ration_report,
  output logic                    ration_disconnect,
  output logic                    ration_sleep
);
  import pscr_pkg::*;

  logic [4:0]  pins_sync;
  logic [7:0]  next_general;
  logic [7:0]  next_emulation;
  logic [7:0]  next_switch;
  logic [7:0]  next_attach;
  logic [7:0]  next_fast_sw;
  logic [7:0]  next_rdata;
  logic        next_hit;
  logic        polarity_high;
  logic        polarity_taken;
  logic        next_polarity_high;
  logic        next_polarity_taken;
  logic [1:0]  sync_fill;
  logic [1:0]  next_sync_fill;
  logic        port_enable_control;
  logic        mode_sel2_status;
  logic        mode_sel1_status;
  logic        emulation_enable_status;
  pscr_power_t power_state_field;
  logic [7:0]  pin_level_status;

  pscr_pin_sync #(
    .WIDTH (5)
  ) u_sync (
    .clock     (clock),
    .reset     (reset),
    .pin_async ({port_enable_pin, mode_sel2_pin, mode_sel1_pin,
                 emulation_enable_pin, polarity_pin}),
    .pin_sync  (pins_sync)
  );

  function automatic logic pick(input logic sel, input logic ovr,
                                input logic pin);
    pick = sel ? ovr : pin;
  endfunction

  // Live mirrors, no extra latency beyond the synchroniser
  always_comb begin
    port_enable_control     = pick(override_select, port_enable_override,
                                   pins_sync[4]);
    mode_sel2_status        = pick(override_select, mode_sel2_override,
                                   pins_sync[3]);
    mode_sel1_status        = pick(override_select, mode_sel1_override,
                                   pins_sync[2]);
    emulation_enable_status = pick(override_select,
                                   emulation_enable_override,
                                   pins_sync[1]);
    // Host access wakes the core, so sleep shows as detect
    power_state_field = (core_power_state == PSCR_PS_SLEEP) ?
                        PSCR_PS_DETECT : core_power_state;
    pin_level_status = {1'b0, port_enable_control, mode_sel2_status,
                        mode_sel1_status, emulation_enable_status,
                        polarity_high, power_state_field};
  end

  assign wake_request = bus_access;

  always_comb begin
    next_polarity_high  = polarity_high;
    next_polarity_taken = polarity_taken;
    next_sync_fill      = sync_fill;
    // Synchroniser restarts from zero, so wait until it holds the pin
    if (sync_fill != 2'(PSCR_SYNC_STAGES)) begin
      next_sync_fill = sync_fill + 2'h1;
    end else if (!polarity_taken) begin
      next_polarity_high  = pins_sync[0];
      next_polarity_taken = 1'b1;
    end
  end

  always_comb begin
    next_general   = general_config;
    next_emulation = emulation_config;
    next_switch    = switch_config;
    next_attach    = attach_detect_config;
    next_fast_sw   = fast_data_switch_config;
    next_rdata     = bus_rdata;
    next_hit       = 1'b0;
    if (bus_access) begin
      next_hit = 1'b1;
      unique case (bus_addr)
        PSCR_ADDR_PIN_STATUS: begin
          if (!bus_write) next_rdata = pin_level_status;
        end
        PSCR_ADDR_GENERAL: begin
          if (bus_write) next_general = bus_wdata & PSCR_GEN_WMASK;
          else next_rdata = general_config;
        end
        PSCR_ADDR_EMULATION: begin
          if (bus_write) next_emulation = bus_wdata;
          else next_rdata = emulation_config;
        end
        PSCR_ADDR_SWITCH: begin
          if (bus_write) next_switch = bus_wdata;
          else next_rdata = switch_config;
        end
        PSCR_ADDR_ATTACH: begin
          if (bus_write) next_attach = bus_wdata;
          else next_rdata = attach_detect_config;
        end
        PSCR_ADDR_FAST_SW: begin
          if (bus_write) next_fast_sw = bus_wdata;
          else next_rdata = fast_data_switch_config;
        end
        default: begin
          next_hit = 1'b0;
          if (!bus_write) next_rdata = 8'h00;
        end
      endcase
    end
  end

  // Reset only on power-on; sleep does not touch these
  always_ff @(posedge clock) begin
    if (reset) begin
      general_config          <= PSCR_RST_GENERAL;
      emulation_config        <= PSCR_RST_EMULATION;
      switch_config           <= PSCR_RST_SWITCH;
      attach_detect_config    <= PSCR_RST_ATTACH;
      fast_data_switch_config <= PSCR_RST_FAST_SW;
      bus_rdata               <= 8'h00;
      bus_hit                 <= 1'b0;
      polarity_high           <= 1'b0;
      polarity_taken          <= 1'b0;
      sync_fill               <= 2'h0;
    end else begin
      general_config          <= next_general;
      emulation_config        <= next_emulation;
      switch_config           <= next_switch;
      attach_detect_config    <= next_attach;
      fast_data_switch_config <= next_fast_sw;
      bus_rdata               <= next_rdata;
      bus_hit                 <= next_hit;
      polarity_high           <= next_polarity_high;
      polarity_taken          <= next_polarity_taken;
      sync_fill               <= next_sync_fill;
    end
  end

  always_comb begin
    bus_discharge       = general_config[PSCR_GEN_DISCHARGE];
    rationing_enable    = general_config[PSCR_GEN_RATIONING_ENABLE];
    rationing_reset     = general_config[PSCR_GEN_RATIONING_RESET];
    rationing_behaviour = pscr_ration_t'(general_config[1:0]);
    ration_report       = (rationing_behaviour ==
                           PSCR_RB_REPORT_DIS);
    ration_disconnect   = rationing_behaviour == PSCR_RB_REPORT_DIS ||
                          rationing_behaviour == PSCR_RB_DIS_SLEEP;
    ration_sleep        = rationing_behaviour == PSCR_RB_DIS_SLEEP;
  end

  a_status_msb: assert property (@(posedge clock) disable iff (reset)
    bus_access && !bus_write && bus_addr == PSCR_ADDR_PIN_STATUS
    |=> !bus_rdata[7]) else $error("status msb set");
  a_port_en_mirror: assert property (@(posedge clock) disable iff (reset)
    pin_level_status[6] == (override_select ? port_enable_override
    : pins_sync[4])) else $error("port enable mirror");
  a_mode2_mirror: assert property (@(posedge clock) disable iff (reset)
    bus_access && !bus_write && bus_addr == PSCR_ADDR_PIN_STATUS
    |=> bus_rdata[5] == $past(mode_sel2_status))
    else $error("mode2 mirror");
  a_mode1_mirror: assert property (@(posedge clock) disable iff (reset)
    pin_level_status[4] == (override_select ? mode_sel1_override
    : pins_sync[2])) else $error("mode1 mirror");
  a_emul_mirror: assert property (@(posedge clock) disable iff (reset)
    pin_level_status[3] == (override_select ? emulation_enable_override
    : pins_sync[1])) else $error("emulation mirror");
  a_polarity_hold: assert property (@(posedge clock) disable iff (reset)
    polarity_taken |=> $stable(polarity_high))
    else $error("polarity changed");
  a_state_no_sleep: assert property (@(posedge clock) disable iff (reset)
    bus_access && !bus_write && bus_addr == PSCR_ADDR_PIN_STATUS
    |=> bus_rdata[1:0] != 2'b00) else $error("sleep code read");
  a_state_pass: assert property (@(posedge clock) disable iff (reset)
    core_power_state != PSCR_PS_SLEEP |->
    pin_level_status[1:0] == core_power_state)
    else $error("power state mismatch");
  a_status_ro: assert property (@(posedge clock) disable iff (reset)
    bus_access && bus_write && bus_addr == PSCR_ADDR_PIN_STATUS
    |=> $stable(general_config) && $stable(bus_rdata))
    else $error("status write had effect");
  a_gen_reset: assert property (@(posedge clock)
    $past(reset) |-> general_config == 8'h01 && emulation_config == 8'h8C)
    else $error("config reset value");
  a_gen_write: assert property (@(posedge clock) disable iff (reset)
    bus_access && bus_write && bus_addr == PSCR_ADDR_GENERAL
    |=> general_config == ($past(bus_wdata) & 8'hBF))
    else $error("general write");
  a_gen_keep: assert property (@(posedge clock) disable iff (reset)
    !(bus_access && bus_write) |=> $stable(general_config))
    else $error("general lost");
  a_ration_dec: assert property (@(posedge clock) disable iff (reset)
    general_config[1:0] == 2'b11 |-> !ration_report && !ration_disconnect)
    else $error("ignore decode");
endmodule

/* shared/pscr_pkg.sv */
// Constants and types for the pin status and configuration register bank
// Overview of operation
// - Status bit 7 is unimplemented and always reads zero.
// - Status bit 6 follows effective port-enable level, pin or override.
// - Status bit 5 follows mode-select-2 pin or its override.
// - Status bit 4 follows mode-select-1 pin or its override.
// - Status bit 3 follows emulation-enable pin or its override.
// - Status bit 2 holds polarity pin decode, latched once after reset.
// - Status bits 1-0: 00 sleep, 01 detect, 10 active, 11 error.
// - Any serial access wakes the device, so reads never show sleep.
// - Configuration registers load 01h, 8Ch, 04h, 46h, 14h at reset.
// - General configuration keeps its contents through sleep entry and exit.
// - General configuration fields at bits 7, 5, 4, 3, 2 and 1-0.
// - Rationing 01 report+disconnect, 10 disconnect+sleep, 11 ignore.
package pscr_pkg;
  localparam logic [7:0] PSCR_ADDR_PIN_STATUS = 8'h14;
  localparam logic [7:0] PSCR_ADDR_GENERAL    = 8'h15;
  localparam logic [7:0] PSCR_ADDR_EMULATION  = 8'h16;
  localparam logic [7:0] PSCR_ADDR_SWITCH     = 8'h17;
  localparam logic [7:0] PSCR_ADDR_ATTACH     = 8'h18;
  localparam logic [7:0] PSCR_ADDR_FAST_SW    = 8'h25;
  localparam logic [7:0] PSCR_RST_GENERAL     = 8'h01;
  localparam logic [7:0] PSCR_RST_EMULATION   = 8'h8C;
  localparam logic [7:0] PSCR_RST_SWITCH      = 8'h04;
  localparam logic [7:0] PSCR_RST_ATTACH      = 8'h46;
  localparam logic [7:0] PSCR_RST_FAST_SW     = 8'h14;
  localparam logic [7:0] PSCR_GEN_WMASK       = 8'hBF;
  localparam int PSCR_GEN_ALERT_MASK = 7;
  localparam int PSCR_GEN_ALERT_LINK = 5;
  localparam int PSCR_GEN_DISCHARGE  = 4;
  localparam int PSCR_GEN_RATIONING_ENABLE     = 3;
  localparam int PSCR_GEN_RATIONING_RESET    = 2;
  localparam int PSCR_SYNC_STAGES    = 2;

  typedef enum logic [1:0] {
    PSCR_PS_SLEEP  = 2'b00,
    PSCR_PS_DETECT = 2'b01,
    PSCR_PS_ACTIVE = 2'b10,
    PSCR_PS_ERROR  = 2'b11
  } pscr_power_t;

  typedef enum logic [1:0] {
    PSCR_RB_RSVD       = 2'b00,
    PSCR_RB_REPORT_DIS = 2'b01,
    PSCR_RB_DIS_SLEEP  = 2'b10,
    PSCR_RB_IGNORE     = 2'b11
  } pscr_ration_t;
endpackage

/* verilog/pscr_pin_sync.sv */
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/100ps
module pscr_pin_sync #(
  parameter int WIDTH = 5
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pin_async,
  output logic      [WIDTH-1:0] pin_sync
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync;

  always_comb begin
    next_stage1 = pin_async;
    next_sync   = stage1;
  end

  // First stage read only by the second
  always_ff @(posedge clock) begin
    if (reset) begin
      stage1   <= '0;
      pin_sync <= '0;
    end else begin
      stage1   <= next_stage1;
      pin_sync <= next_sync;
    end
  end
endmodule

/* tb/pscr_host.sv */
// Host model issuing single-byte register accesses
`timescale 1ns/100ps
module pscr_host (
  input  wire logic       clock,
  output logic            bus_access,
  output logic            bus_write,
  output logic [7:0]      bus_addr,
  output logic [7:0]      bus_wdata,
  input  wire logic [7:0] bus_rdata,
  input  wire logic       bus_hit
);
  initial begin
    bus_access = 1'b0;
    bus_write  = 1'b0;
    bus_addr   = 8'hA5;
    bus_wdata  = 8'h5A;
  end
  // One-cycle request; answer sampled one cycle later
  task automatic xfer(input logic wr, input logic [7:0] addr,
                      input logic [7:0] wdata, output logic [7:0] rdata,
                      output logic hit);
    @(negedge clock);
    bus_access = 1'b1;
    bus_write  = wr;
    bus_addr   = addr;
    bus_wdata  = wdata;
    @(negedge clock);
    rdata = bus_rdata;
    hit   = bus_hit;
    // Released lines flip so stale values never pass as answers
    bus_access = 1'b0;
    bus_write  = ~wr;
    bus_addr   = ~addr;
    bus_wdata  = ~wdata;
  endtask
endmodule

/* tb/pscr_regs_tb.sv */
// Self-checking testbench for the pin status and configuration bank
`timescale 1ns/100ps
`define CHK(a, e) begin \
  total_checks++; \
  if ((a) !== (e)) begin \
    error_cnt++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (e)); \
  end \
end
module pscr_regs_tb;
  import pscr_pkg::*;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        bus_access, bus_write, bus_hit;
  logic [7:0]  bus_addr, bus_wdata, bus_rdata;
  logic [3:0]  pins = 4'h0;
  logic [3:0]  ovr = 4'h0;
  logic        sel = 1'b0;
  logic        pol_pin, pol0;
  pscr_power_t core_st = PSCR_PS_SLEEP;
  logic [7:0]  gen_cfg, emu_cfg, sw_cfg, att_cfg, fast_cfg;
  logic        dis, rten, rtrst, rep, disc, slp;
  pscr_ration_t rbeh;
  int          error_cnt = 0;
  int          total_checks = 0;
  logic [7:0]  addrs [5] = '{8'h15, 8'h16, 8'h17, 8'h18, 8'h25};
  logic [7:0]  rstv [5] = '{PSCR_RST_GENERAL, PSCR_RST_EMULATION,
      PSCR_RST_SWITCH, PSCR_RST_ATTACH, PSCR_RST_FAST_SW};
  logic [7:0]  d, v, g, e;
  logic        h;
  logic        wake;

  always #12.5 clock = ~clock;

  pscr_host pscr_host_i (.clock(clock), .bus_access(bus_access),
    .bus_write(bus_write), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .bus_hit(bus_hit));

  pscr_regs pscr_regs_i (.clock(clock), .reset(reset),
    .bus_access(bus_access), .bus_write(bus_write), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_hit(bus_hit),
    .port_enable_pin(pins[3]), .mode_sel2_pin(pins[2]),
    .mode_sel1_pin(pins[1]), .emulation_enable_pin(pins[0]),
    .polarity_pin(pol_pin), .port_enable_override(ovr[3]),
    .mode_sel2_override(ovr[2]), .mode_sel1_override(ovr[1]),
    .emulation_enable_override(ovr[0]), .override_select(sel),
    .core_power_state(core_st), .wake_request(wake),
    .general_config(gen_cfg), .emulation_config(emu_cfg),
    .switch_config(sw_cfg), .attach_detect_config(att_cfg),
    .fast_data_switch_config(fast_cfg), .bus_discharge(dis),
    .rationing_enable(rten), .rationing_reset(rtrst),
    .rationing_behaviour(rbeh), .ration_report(rep),
    .ration_disconnect(disc), .ration_sleep(slp));

  function automatic logic [7:0] exp_status(input logic [3:0] p, o,
      input logic s, pl, input logic [1:0] st);
    // Sleep never shows: any access wakes the core first
    return {1'b0, (s ? o : p), pl, (st == 2'b00) ? 2'b01 : st};
  endfunction

  function automatic logic [2:0] exp_rb(input logic [1:0] b);
    case (b)
      2'b01:   return 3'b110;
      2'b10:   return 3'b011;
      default: return 3'b000;
    endcase
  endfunction

  task automatic stop_test();
    if (error_cnt == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    stop_test();
  end

  initial begin
    void'($urandom(88));
    pol0 = 1'($urandom);
    pol_pin = pol0;
    repeat (12) @(negedge clock);
    reset = 1'b0;
    `CHK(gen_cfg, PSCR_RST_GENERAL)
    `CHK({emu_cfg, sw_cfg, att_cfg, fast_cfg}, 32'h8C044614)
    for (int i = 0; i < 5; i++) begin
      pscr_host_i.xfer(1'b0, addrs[i], 8'h00, d, h);
      `CHK({h, d}, {1'b1, rstv[i]})
    end
    pscr_host_i.xfer(1'b0, 8'h19, 8'h00, d, h);
    `CHK({h, d}, 9'h000)
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 8'hFF : 8'($urandom);
      pscr_host_i.xfer(1'b1, addrs[i], v, d, h);
      pscr_host_i.xfer(1'b0, addrs[i], 8'h00, d, h);
      `CHK(d, (i == 0) ? (v & 8'hBF) : v)
    end
    for (int b = 0; b < 4; b++) begin
      v = {6'($urandom), b[1:0]};
      pscr_host_i.xfer(1'b1, 8'h15, v, d, h);
      `CHK({dis, rten, rtrst, rbeh}, v[4:0])
      `CHK({rep, disc, slp}, exp_rb(v[1:0]))
    end
    g = v & 8'hBF;
    for (int n = 0; n < 40; n++) begin
      @(negedge clock);
      // Corner cases first: all-pins-high, then overrides winning
      pins = (n == 0) ? 4'hF : 4'($urandom);
      ovr = 4'($urandom);
      sel = (n == 1) ? 1'b1 : 1'($urandom);
      pol_pin = 1'($urandom);
      core_st = pscr_power_t'((n < 4) ? 2'(n) : 2'($urandom));
      repeat (3) @(negedge clock);
      e = exp_status(pins, ovr, sel, pol0, core_st);
      `CHK(wake, 1'b0)
      fork
        pscr_host_i.xfer(1'b0, 8'h14, 8'h00, d, h);
        begin
          repeat (2) @(posedge clock);
          `CHK(wake, 1'b1)
        end
      join
      `CHK(d, e)
      `CHK(h, 1'b1)
      pscr_host_i.xfer(1'b1, 8'h14, ~e, d, h);
      pscr_host_i.xfer(1'b0, 8'h14, 8'h00, d, h);
      `CHK(d, e)
      `CHK(gen_cfg, g)
    end
    stop_test();
  end
endmodule
